// ===== core/fpc_map.svh
`ifndef FPC_MAP_SVH
`define FPC_MAP_SVH

// register indices; byte address is four times the index
`define FPC_IDX_CR1        4'h0
`define FPC_IDX_CMD        4'h1
`define FPC_IDX_CMD_INV    4'h2
`define FPC_IDX_BOOT       4'h3
`define FPC_IDX_BOOT_INV   4'h4
`define FPC_IDX_STATUS     4'h5
`define FPC_IDX_PKEY       4'h8
`define FPC_IDX_EKEY       4'hA

// reset values
`define FPC_RST_CR1        8'h00
`define FPC_RST_CMD        8'h00
`define FPC_RST_CMD_INV    8'hFF
`define FPC_RST_BOOT       8'h00
`define FPC_RST_BOOT_INV   8'hFF
`define FPC_RST_STATUS     8'h40
`define FPC_KEY_READ       8'h00

// control one fields
`define FPC_BIT_FIX        0
`define FPC_BIT_IE         1
`define FPC_BIT_AHALT      2
`define FPC_BIT_HALT       3
`define FPC_CR1_MASK       8'h0F

// command and inverse fields
`define FPC_BIT_OPT        7
`define FPC_BIT_WORD       6
`define FPC_BIT_ERASE      5
`define FPC_BIT_FAST       4
`define FPC_BIT_BLOCK      0
`define FPC_CMD_MASK       8'hF1
`define FPC_OPS_MASK       8'h71
`define FPC_BOOT_MASK      8'h3F

// status fields
`define FPC_BIT_HV         6
`define FPC_BIT_EUL        3
`define FPC_BIT_EOP        2
`define FPC_BIT_PUL        1
`define FPC_BIT_WPD        0

// timing
`define FPC_CLK_NS         8
`define FPC_T_PROG_NS      6000
`define FPC_T_ERASE_NS     6000

// unlock keys, arbitrary values
`define FPC_KEY_FIRST      8'hA5
`define FPC_KEY_SECOND     8'h5A

`endif

// ===== core/fpc_pkg.sv
package fpc_pkg;

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic        hready;
      logic [31:0] hwdata;
   } fpc_ahb_req_s;

   typedef enum logic [2:0] {
      FPC_SEQ_IDLE  = 3'b001,
      FPC_SEQ_ERASE = 3'b010,
      FPC_SEQ_PROG  = 3'b100
   } fpc_seq_e;

   typedef enum logic [2:0] {
      FPC_KEY_IDLE = 3'b001,
      FPC_KEY_ONE  = 3'b010,
      FPC_KEY_DEAD = 3'b100
   } fpc_key_e;

endpackage

// ===== core/fpc_keys.sv
`timescale 1ns/1ps
`include "fpc_map.svh"

module fpc_keys
   import fpc_pkg::*;
#(
   parameter logic [7:0] KEY_FIRST  = `FPC_KEY_FIRST,
   parameter logic [7:0] KEY_SECOND = `FPC_KEY_SECOND,
   parameter bit         RETRY      = 1'b1
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_wr,
   input  wire logic [7:0] i_data,
   output logic            o_unlock
);

   fpc_key_e state_q;

   // a bad key either rearms the checker or kills it until reset
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q  <= FPC_KEY_IDLE;
         o_unlock <= 1'b0;
      end else begin
         o_unlock <= 1'b0;
         case (state_q)
            FPC_KEY_IDLE: begin
               if (i_wr) begin
                  if (i_data == KEY_FIRST) begin
                     state_q <= FPC_KEY_ONE;
                  end else if (!RETRY) begin
                     state_q <= FPC_KEY_DEAD;
                  end
               end
            end
            FPC_KEY_ONE: begin
               if (i_wr) begin
                  if (i_data == KEY_SECOND) begin
                     o_unlock <= 1'b1;
                     state_q  <= FPC_KEY_IDLE;
                  end else if (RETRY) begin
                     state_q <= FPC_KEY_IDLE;
                  end else begin
                     state_q <= FPC_KEY_DEAD;
                  end
               end
            end
            FPC_KEY_DEAD: begin
               state_q <= FPC_KEY_DEAD;
            end
            default: begin
               state_q <= FPC_KEY_IDLE;
            end
         endcase
      end
   end

endmodule

// ===== core/fpc_regs.sv
// Notes on behaviour
// [RULE1] inverse option bit is software owned; 0 allows option byte writes
// [RULE2] clearing word inverse starts word programming; hardware sets it back
// [RULE3] clearing erase inverse starts block erase; hardware sets it back
// [RULE4] fast inverse cleared by software write, set by reading its register
// [RULE5] fast block programming skips the erase phase
// [RULE6] clearing block inverse starts block programming; hardware sets it back
// [RULE7] boot size bits load from the boot option byte at startup
// [RULE8] inverse boot size bits mirror the inverse option byte, top bits spare
// [RULE9] program key register takes writes and always reads zero
// [RULE10] eeprom key register takes writes and always reads zero
// [RULE11] high voltage done is low during an operation, high otherwise
// [RULE12] status bits five and four always read zero
// [RULE13] eeprom unlocked set by correct keys, cleared by writing zero
// [RULE14] op finished set at operation end, cleared by status read or start
// [RULE15] op finished with irq enable raises the flash interrupt
// [RULE16] program unlocked set by correct keys, cleared by writing zero
// [RULE17] protected write flag set on locked write, cleared by status read
// [RULE18] irq enable is software owned and gates both status events
// [RULE19] a bad program key sequence locks the checker until reset
// [RULE20] a bad eeprom key sequence may be retried without reset
// [RULE21] software writes each request with its inverse bit cleared
// [RULE22] an operation on a locked area only flags a protected write
`timescale 1ns/1ps
`include "fpc_map.svh"

module fpc_regs
   import fpc_pkg::*;
#(
   parameter int unsigned T_PROG_NS  = `FPC_T_PROG_NS,
   parameter int unsigned T_ERASE_NS = `FPC_T_ERASE_NS
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire fpc_ahb_req_s i_ahb,
   input  wire logic [7:0]   i_boot_opt,
   input  wire logic [7:0]   i_boot_opt_inv,
   input  wire logic         i_target_data,
   input  wire logic         i_wr_protected,
   output logic              o_hreadyout,
   output logic [31:0]       o_hrdata,
   output logic              o_hresp,
   output logic              o_irq,
   output logic              o_op_active,
   output logic              o_fast_op,
   output logic              o_opt_write_en,
   output logic              o_fix_time,
   output logic              o_halt_run,
   output logic              o_ahalt_pd
);

   localparam int unsigned PROG_CYC_I =
      (T_PROG_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS;
   localparam int unsigned ERASE_CYC_I =
      (T_ERASE_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS;
   localparam logic [15:0] PROG_CYC  =
      16'((PROG_CYC_I  < 1) ? 1 : PROG_CYC_I);
   localparam logic [15:0] ERASE_CYC =
      16'((ERASE_CYC_I < 1) ? 1 : ERASE_CYC_I);

   logic [7:0]  cr1_q;
   logic [7:0]  cmd_q;
   logic [7:0]  inv_q;
   logic [7:0]  boot_q;
   logic [7:0]  boot_inv_q;
   logic        load_q;
   logic        hv_q;
   logic        eul_q;
   logic        eop_q;
   logic        pul_q;
   logic        wpd_q;
   logic        wr_q;
   logic [3:0]  wr_idx_q;
   fpc_seq_e    seq_q;
   logic [15:0] cnt_q;
   logic [7:0]  kind_q;

   logic        acc;
   logic        rd;
   logic [3:0]  idx;
   logic [7:0]  wdat;
   logic [7:0]  req;
   logic [7:0]  pick;
   logic        locked;
   logic        launch;
   logic        reject;
   logic        done;
   logic        pkey_unlock;
   logic        ekey_unlock;
   logic        st_rd;

   // highest set bit wins among pending operations, word first
   function automatic logic [7:0] first_req(input logic [7:0] r);
      logic [7:0] p;
      p = 8'h00;
      if (r[`FPC_BIT_WORD]) begin
         p[`FPC_BIT_WORD] = 1'b1;
      end else if (r[`FPC_BIT_ERASE]) begin
         p[`FPC_BIT_ERASE] = 1'b1;
      end else if (r[`FPC_BIT_FAST]) begin
         p[`FPC_BIT_FAST] = 1'b1;
      end else if (r[`FPC_BIT_BLOCK]) begin
         p[`FPC_BIT_BLOCK] = 1'b1;
      end
      return p;
   endfunction

   function automatic logic [7:0] read_mux(input logic [3:0] i,
                                           input logic [7:0] cr1,
                                           input logic [7:0] cmd,
                                           input logic [7:0] inv,
                                           input logic [7:0] bt,
                                           input logic [7:0] bti,
                                           input logic [7:0] st);
      logic [7:0] v;
      v = 8'h00;
      if (i == `FPC_IDX_CR1) begin
         v = cr1;
      end else if (i == `FPC_IDX_CMD) begin
         v = cmd;
      end else if (i == `FPC_IDX_CMD_INV) begin
         v = inv;
      end else if (i == `FPC_IDX_BOOT) begin
         v = bt;
      end else if (i == `FPC_IDX_BOOT_INV) begin
         v = bti;
      end else if (i == `FPC_IDX_STATUS) begin
         v = st;
      end else if (i == `FPC_IDX_PKEY || i == `FPC_IDX_EKEY) begin
         v = `FPC_KEY_READ; // RULE9 RULE10
      end
      return v;
   endfunction

   assign acc  = i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready;
   assign rd   = acc && !i_ahb.hwrite;
   assign idx  = i_ahb.haddr[5:2];
   assign wdat = i_ahb.hwdata[7:0];
   assign st_rd = rd && (idx == `FPC_IDX_STATUS);

   // bus slave: zero wait states, data phase follows the address phase
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_q        <= 1'b0;
         wr_idx_q    <= 4'h0;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         o_hrdata    <= 32'h0000_0000;
      end else begin
         wr_q        <= acc && i_ahb.hwrite;
         wr_idx_q    <= idx;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         if (rd) begin
            o_hrdata <= {24'h00_0000,
                         read_mux(idx, cr1_q, cmd_q, inv_q, boot_q,
                                  boot_inv_q,
                                  {1'b0, hv_q, 2'b00, eul_q, eop_q,
                                   pul_q, wpd_q})}; // RULE12
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cr1_q <= `FPC_RST_CR1;
      end else if (wr_q && wr_idx_q == `FPC_IDX_CR1) begin
         cr1_q <= wdat & `FPC_CR1_MASK; // RULE18
      end
   end

   // request pending when the bit is set and its inverse is cleared
   assign req    = cmd_q & ~inv_q & `FPC_OPS_MASK; // RULE21
   assign pick   = first_req(req);
   assign locked = i_target_data ? !eul_q : !pul_q;
   assign launch = (seq_q == FPC_SEQ_IDLE) && (|req) && !locked;
   assign reject = (seq_q == FPC_SEQ_IDLE) && (|req) && locked; // RULE22
   assign done   = (seq_q != FPC_SEQ_IDLE) && (cnt_q == 16'h0001) &&
                   !(seq_q == FPC_SEQ_ERASE && kind_q[`FPC_BIT_BLOCK]);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cmd_q <= `FPC_RST_CMD;
         inv_q <= `FPC_RST_CMD_INV;
      end else begin
         // writes leave the erase and fast bits alone while an operation runs
         if (wr_q && wr_idx_q == `FPC_IDX_CMD) begin
            cmd_q <= (wdat & `FPC_CMD_MASK);
            if (seq_q != FPC_SEQ_IDLE) begin
               cmd_q[`FPC_BIT_ERASE] <= cmd_q[`FPC_BIT_ERASE];
               cmd_q[`FPC_BIT_FAST]  <= cmd_q[`FPC_BIT_FAST];
            end
         end
         if (wr_q && wr_idx_q == `FPC_IDX_CMD_INV) begin
            inv_q <= wdat | ~`FPC_CMD_MASK; // RULE1
            if (seq_q != FPC_SEQ_IDLE) begin
               inv_q[`FPC_BIT_ERASE] <= inv_q[`FPC_BIT_ERASE];
               inv_q[`FPC_BIT_FAST]  <= inv_q[`FPC_BIT_FAST];
            end
         end
         if (rd && idx == `FPC_IDX_CMD_INV) begin
            inv_q[`FPC_BIT_FAST] <= 1'b1; // RULE4
         end
         // only the finished or refused bit moves, so a same-cycle write or
         // read keeps the rest; fast inverse is restored by a read or a refusal, never by a finish
         for (int b = 0; b < 8; b++) begin
            if ((reject && pick[b]) || (done && kind_q[b])) begin
               cmd_q[b] <= 1'b0;
            end
            if ((reject && pick[b]) ||
                (done && kind_q[b] && b != `FPC_BIT_FAST)) begin
               inv_q[b] <= 1'b1; // RULE2 RULE3 RULE6
            end
         end
      end
   end

   // block programming erases first; fast programming does not
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         seq_q  <= FPC_SEQ_IDLE;
         cnt_q  <= 16'h0000;
         kind_q <= 8'h00;
      end else begin
         case (seq_q)
            FPC_SEQ_IDLE: begin
               if (launch) begin
                  kind_q <= pick;
                  if (pick[`FPC_BIT_ERASE] || pick[`FPC_BIT_BLOCK]) begin
                     seq_q <= FPC_SEQ_ERASE; // RULE3 RULE6
                     cnt_q <= ERASE_CYC;
                  end else begin
                     seq_q <= FPC_SEQ_PROG; // RULE2 RULE5
                     cnt_q <= PROG_CYC;
                  end
               end
            end
            FPC_SEQ_ERASE: begin
               if (cnt_q == 16'h0001) begin
                  if (kind_q[`FPC_BIT_BLOCK]) begin
                     seq_q <= FPC_SEQ_PROG;
                     cnt_q <= PROG_CYC;
                  end else begin
                     seq_q <= FPC_SEQ_IDLE;
                     cnt_q <= 16'h0000;
                  end
               end else begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            FPC_SEQ_PROG: begin
               if (cnt_q == 16'h0001) begin
                  seq_q <= FPC_SEQ_IDLE;
                  cnt_q <= 16'h0000;
               end else begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            default: begin
               seq_q <= FPC_SEQ_IDLE;
            end
         endcase
      end
   end

   // option bytes settle during reset, so capture one cycle after release
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         load_q     <= 1'b1;
         boot_q     <= `FPC_RST_BOOT;
         boot_inv_q <= `FPC_RST_BOOT_INV;
      end else if (load_q) begin
         load_q     <= 1'b0;
         boot_q     <= i_boot_opt & `FPC_BOOT_MASK; // RULE7
         boot_inv_q <= (i_boot_opt_inv & `FPC_BOOT_MASK) |
                       ~`FPC_BOOT_MASK; // RULE8
      end
   end

   fpc_keys #(
      .KEY_FIRST  (`FPC_KEY_FIRST),
      .KEY_SECOND (`FPC_KEY_SECOND),
      .RETRY      (1'b0)
   ) u_pkey (
      .i_clk    (i_clk),
      .i_rst    (i_rst),
      .i_wr     (wr_q && wr_idx_q == `FPC_IDX_PKEY), // RULE9 RULE19
      .i_data   (wdat),
      .o_unlock (pkey_unlock)
   );

   fpc_keys #(
      .KEY_FIRST  (`FPC_KEY_FIRST),
      .KEY_SECOND (`FPC_KEY_SECOND),
      .RETRY      (1'b1)
   ) u_ekey (
      .i_clk    (i_clk),
      .i_rst    (i_rst),
      .i_wr     (wr_q && wr_idx_q == `FPC_IDX_EKEY), // RULE10 RULE20
      .i_data   (wdat),
      .o_unlock (ekey_unlock)
   );

   // unlock flags: hardware set wins over a software clear
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pul_q <= 1'b0;
         eul_q <= 1'b0;
      end else begin
         if (pkey_unlock) begin
            pul_q <= 1'b1; // RULE16
         end else if (wr_q && wr_idx_q == `FPC_IDX_STATUS &&
                      !wdat[`FPC_BIT_PUL]) begin
            pul_q <= 1'b0; // RULE16
         end
         if (ekey_unlock) begin
            eul_q <= 1'b1; // RULE13
         end else if (wr_q && wr_idx_q == `FPC_IDX_STATUS &&
                      !wdat[`FPC_BIT_EUL]) begin
            eul_q <= 1'b0; // RULE13
         end
      end
   end

   // event flags: a set in the clearing read cycle survives
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         eop_q <= 1'b0;
         wpd_q <= 1'b0;
         hv_q  <= 1'(`FPC_RST_STATUS >> `FPC_BIT_HV);
      end else begin
         if (done) begin
            eop_q <= 1'b1; // RULE14
         end else if (st_rd || launch) begin
            eop_q <= 1'b0; // RULE14
         end
         if (reject || i_wr_protected) begin
            wpd_q <= 1'b1; // RULE17
         end else if (st_rd) begin
            wpd_q <= 1'b0; // RULE17
         end
         if (launch) begin
            hv_q <= 1'b0; // RULE11
         end else if (done) begin
            hv_q <= 1'b1; // RULE11
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_irq          <= 1'b0;
         o_op_active    <= 1'b0;
         o_fast_op      <= 1'b0;
         o_opt_write_en <= 1'b0;
         o_fix_time     <= 1'b0;
         o_halt_run     <= 1'b0;
         o_ahalt_pd     <= 1'b0;
      end else begin
         o_irq          <= cr1_q[`FPC_BIT_IE] && (eop_q || wpd_q); // RULE15 RULE18
         o_op_active    <= (seq_q != FPC_SEQ_IDLE) || launch;
         o_fast_op      <= kind_q[`FPC_BIT_FAST] && (seq_q != FPC_SEQ_IDLE);
         o_opt_write_en <= !inv_q[`FPC_BIT_OPT]; // RULE1
         o_fix_time     <= cr1_q[`FPC_BIT_FIX];
         o_halt_run     <= cr1_q[`FPC_BIT_HALT];
         o_ahalt_pd     <= cr1_q[`FPC_BIT_AHALT];
      end
   end

endmodule

// ===== sim/fpc_regs_checker.sv
`timescale 1ns/1ps

module fpc_regs_checker
   import fpc_pkg::*;
#(
   parameter int unsigned T_PROG_NS  = 6000,
   parameter int unsigned T_ERASE_NS = 6000
) (
   input wire logic         i_clk,
   input wire logic         i_rst,
   input wire fpc_ahb_req_s i_ahb,
   input wire logic [7:0]   i_boot_opt,
   input wire logic [7:0]   i_boot_opt_inv,
   input wire logic         i_wr_protected,
   input wire logic [31:0]  o_hrdata,
   input wire logic         o_irq,
   input wire logic         o_op_active,
   input wire logic         o_fast_op,
   input wire logic         o_opt_write_en
);
   localparam int FAST_MAX = T_PROG_NS / 8 + 3;
   localparam int OP_MAX   = (T_PROG_NS + T_ERASE_NS) / 8 + 3;

   logic       rd_q;
   logic       wr_q;
   logic       opt_q;
   logic [3:0] idx_q;
   wire        take = i_ahb.hsel & i_ahb.htrans[1] & i_ahb.hready;

   // data phase tracking: rd_q/wr_q are high while hrdata/hwdata stand
   always_ff @(posedge i_clk) begin
      rd_q <= ~i_rst & take & ~i_ahb.hwrite;
      wr_q <= ~i_rst & take & i_ahb.hwrite;
      if (take)
         idx_q <= i_ahb.haddr[5:2];
   end

   always_ff @(posedge i_clk) begin
      if (wr_q && idx_q == 4'h2)
         opt_q <= ~i_ahb.hwdata[7];
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_busy_min;
      o_op_active [*8];
   endsequence

   sequence s_status_rd;
      rd_q && idx_q == 4'h5;
   endsequence

   a_key_read_zero: assert property (
      rd_q && (idx_q == 4'h8 || idx_q == 4'hA) |-> o_hrdata == 32'h0)
      else $error("key register read not zero");
   a_status_spare: assert property (
      s_status_rd |-> o_hrdata[31:7] == 25'h0 && o_hrdata[5:4] == 2'b00)
      else $error("status spare bits not zero");
   a_boot_size_load: assert property (
      rd_q && idx_q == 4'h3 |-> o_hrdata == {26'h0, i_boot_opt[5:0]})
      else $error("boot size differs from option byte");
   a_boot_inv_mirror: assert property (
      rd_q && idx_q == 4'h4
      |-> o_hrdata == {24'h0, 2'b11, i_boot_opt_inv[5:0]})
      else $error("inverse boot size differs from option byte");
   a_opt_follows: assert property (
      wr_q && idx_q == 4'h2 |=> ##1 o_opt_write_en == opt_q)
      else $error("option write enable not inverse of bit 7");
   a_hv_busy_low: assert property (
      s_status_rd ##0 ($past(o_op_active) && o_op_active) |-> !o_hrdata[6])
      else $error("high voltage done set during operation");
   a_irq_read_clr: assert property (
      s_status_rd ##0 (!$past(o_op_active) && !$past(i_wr_protected))
      |=> !o_irq)
      else $error("interrupt stays after status read");
   a_op_bounded: assert property (
      $rose(o_op_active) |-> s_busy_min ##[1:OP_MAX] !o_op_active)
      else $error("operation length out of range");
   a_fast_no_erase: assert property (
      $rose(o_fast_op) |-> ##[1:FAST_MAX] !o_op_active)
      else $error("fast program lasted longer than programming");
endmodule

bind fpc_regs fpc_regs_checker #(
   .T_PROG_NS  (T_PROG_NS),
   .T_ERASE_NS (T_ERASE_NS)
) u_chk (
   .i_clk          (i_clk),
   .i_rst          (i_rst),
   .i_ahb          (i_ahb),
   .i_boot_opt     (i_boot_opt),
   .i_boot_opt_inv (i_boot_opt_inv),
   .i_wr_protected (i_wr_protected),
   .o_hrdata       (o_hrdata),
   .o_irq          (o_irq),
   .o_op_active    (o_op_active),
   .o_fast_op      (o_fast_op),
   .o_opt_write_en (o_opt_write_en)
);

// ===== sim/tb.sv
`timescale 1ns/1ps
`include "fpc_map.svh"

module tb
   import fpc_pkg::*;
;
   typedef struct packed {
      logic       w;
      logic [3:0] ix;
      logic [7:0] d;
      logic [7:0] e;
   } fpc_row_s;

   localparam int T_NS = 80;

   logic         i_clk, i_rst, hsel, hwrite, tgt, wprot, fast;
   logic [1:0]   htrans;
   logic [31:0]  haddr, hwdata, rq, o_hrdata;
   logic [7:0]   bopt, bopt_inv, m;
   logic         o_hreadyout, o_hresp, o_irq, o_op_active, o_fast_op;
   logic         o_opt_write_en, o_fix_time, o_halt_run, o_ahalt_pd;
   fpc_ahb_req_s ahb;
   int           errors, check_count;
   int           ks [4] = '{6, 5, 4, 0};
   // write (optional) then read back; rows 13 and 16 are wrong key bytes
   fpc_row_s     rows [18] = '{
      {1'b0, 4'h0, 8'h00, 8'h00},
      {1'b0, 4'h1, 8'h00, 8'h00},
      {1'b0, 4'h2, 8'h00, 8'hFF},
      {1'b0, 4'h3, 8'h00, 8'h2B},
      {1'b0, 4'h4, 8'h00, 8'hD4},
      {1'b0, 4'h5, 8'h00, 8'h40},
      {1'b0, 4'h8, 8'h00, 8'h00},
      {1'b0, 4'hA, 8'h00, 8'h00},
      {1'b0, 4'h6, 8'h00, 8'h00},
      {1'b1, 4'h0, 8'hFF, 8'h0F},
      {1'b1, 4'h3, 8'h00, 8'h2B},
      {1'b1, 4'h4, 8'h00, 8'hD4},
      {1'b1, 4'h5, 8'hFF, 8'h40},
      {1'b1, 4'h8, 8'h33, 8'h00},
      {1'b1, 4'h1, 8'hFF, 8'hF1},
      {1'b1, 4'h1, 8'h00, 8'h00},
      {1'b1, 4'hA, 8'h33, 8'h00},
      {1'b1, 4'h2, 8'h7F, 8'h7F}
   };

   assign ahb = {hsel, haddr, htrans, hwrite, 3'b010, o_hreadyout, hwdata};

   fpc_regs #(
      .T_PROG_NS  (T_NS),
      .T_ERASE_NS (T_NS)
   ) dut (
      .i_clk          (i_clk),
      .i_rst          (i_rst),
      .i_ahb          (ahb),
      .i_boot_opt     (bopt),
      .i_boot_opt_inv (bopt_inv),
      .i_target_data  (tgt),
      .i_wr_protected (wprot),
      .o_hreadyout    (o_hreadyout),
      .o_hrdata       (o_hrdata),
      .o_hresp        (o_hresp),
      .o_irq          (o_irq),
      .o_op_active    (o_op_active),
      .o_fast_op      (o_fast_op),
      .o_opt_write_en (o_opt_write_en),
      .o_fix_time     (o_fix_time),
      .o_halt_run     (o_halt_run),
      .o_ahalt_pd     (o_ahalt_pd)
   );

   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] g,
                      input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   // single word transfer; read data taken at the data phase edge
   task automatic bus(input logic w, input logic [3:0] ix,
                      input logic [7:0] d);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {26'h0, ix, 2'b00};
      do @(posedge i_clk); while (o_hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge i_clk); while (o_hreadyout !== 1'b1);
      rq = o_hrdata;
   endtask

   task automatic wr(input logic [3:0] ix, input logic [7:0] d);
      bus(1'b1, ix, d);
   endtask

   task automatic rd(input string n, input logic [3:0] ix,
                     input logic [7:0] e);
      bus(1'b0, ix, 8'h00);
      chk(n, rq, {24'h0, e});
   endtask

   task automatic busy(input logic v);
      int n;
      n = 0;
      while (o_op_active !== v && n < 40) begin
         @(posedge i_clk);
         n++;
      end
      chk("busy", {31'h0, o_op_active}, {31'h0, v});
   endtask

   task automatic do_reset();
      i_rst <= 1'b1;
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
   endtask

   initial begin
      repeat (4000) @(posedge i_clk);
      errors++;
      $display("CHECK FAILED watchdog exp finish got hang");
      end_of_test();
   end

   initial begin
      i_rst = 1'b1;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'b00;
      haddr = 32'h0;
      hwdata = 32'h0;
      bopt = 8'hEB;
      bopt_inv = 8'h14;
      tgt = 1'b0;
      wprot = 1'b0;
      errors = 0;
      check_count = 0;
      do_reset();
      for (int i = 0; i < 18; i++) begin
         if (rows[i].w)
            wr(rows[i].ix, rows[i].d);
         rd("row", rows[i].ix, rows[i].e);
      end
      cyc(1);
      chk("ctl_out", {29'h0, o_fix_time, o_halt_run, o_ahalt_pd}, 32'h7);
      chk("bus_rsp", {30'h0, o_hreadyout, o_hresp}, 32'h2);
      chk("opt_on", {31'h0, o_opt_write_en}, 32'h1);
      wr(4'h2, 8'hFF);
      cyc(3);
      chk("opt_off", {31'h0, o_opt_write_en}, 32'h0);
      $display("test registers done");
      // the earlier wrong byte must keep program memory locked
      wr(4'h8, `FPC_KEY_FIRST);
      wr(4'h8, `FPC_KEY_SECOND);
      cyc(3);
      rd("pkey_dead", 4'h5, 8'h40);
      do_reset();
      chk("ctl_rst", {29'h0, o_fix_time, o_halt_run, o_ahalt_pd}, 32'h0);
      chk("bus_rst", {30'h0, o_hreadyout, o_hresp}, 32'h2);
      rd("cr1_rst", 4'h0, 8'h00);
      wr(4'h0, 8'h02);
      wr(4'h8, `FPC_KEY_FIRST);
      wr(4'h8, `FPC_KEY_SECOND);
      wr(4'hA, 8'h11);
      wr(4'hA, `FPC_KEY_FIRST);
      wr(4'hA, `FPC_KEY_SECOND);
      cyc(3);
      rd("unlocked", 4'h5, 8'h4A);
      $display("test keys done");
      foreach (ks[j]) begin
         m = 8'h01 << ks[j];
         tgt <= (ks[j] == 5);
         wr(4'h1, m);
         wr(4'h2, ~m);
         busy(1'b1);
         rd("hv_low", 4'h5, 8'h0A);
         fast = o_fast_op;
         busy(1'b0);
         cyc(2);
         chk("fast", {31'h0, fast}, {31'h0, ks[j] == 4});
         chk("irq_eop", {31'h0, o_irq}, 32'h1);
         rd("cmd_done", 4'h1, 8'h00);
         rd("inv_done", 4'h2, ks[j] == 4 ? 8'hEF : 8'hFF);
         rd("inv_again", 4'h2, 8'hFF);
         if (j == 3)
            rd("eop_set", 4'h5, 8'h4E);
      end
      rd("eop_clr", 4'h5, 8'h4A);
      $display("test operations done");
      wr(4'h5, 8'h00);
      rd("relock", 4'h5, 8'h40);
      wr(4'h1, 8'h40);
      wr(4'h2, 8'hBF);
      cyc(3);
      chk("no_op", {31'h0, o_op_active}, 32'h0);
      chk("irq_wpd", {31'h0, o_irq}, 32'h1);
      rd("wpd_set", 4'h5, 8'h41);
      rd("wpd_clr", 4'h5, 8'h40);
      rd("cmd_rej", 4'h1, 8'h00);
      rd("inv_rej", 4'h2, 8'hFF);
      wr(4'h0, 8'h00);
      wprot <= 1'b1;
      cyc(1);
      wprot <= 1'b0;
      cyc(3);
      chk("irq_off", {31'h0, o_irq}, 32'h0);
      rd("wpd_pin", 4'h5, 8'h41);
      $display("test protection done");
      end_of_test();
   end
endmodule
